// ### shared/nfc_pkg.sv
// nfc_pkg: constants shared by the host-side nand command/address/id controller.
// assumes one 20 MHz clock and a device reached only through its own pins.
`default_nettype none
package nfc_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int STROBE_LOW_NS = 50;
	localparam int STROBE_HIGH_NS = 50;
	localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;
	// ****************************************
	// commands
	// ****************************************
	localparam logic [7:0] CMD_DUMMY = 8'h00;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_IDENT = 8'h90;
	localparam logic [7:0] CMD_DIE0_STATUS = 8'hf2;
	localparam logic [7:0] CMD_DIE1_STATUS = 8'hf3;
	localparam logic [7:0] IDENT_ADDR = 8'h00;
	localparam int IDENT_BYTES = 5;
	// ****************************************
	// address map
	// ****************************************
	localparam int COL_W = 12;
	localparam int ROW_W = 19;
	localparam int ADDR_CYCLES = 5;
	localparam int PAGE_W = 6;
	localparam int PLANE_POS = 6;
	localparam int ROW_DIE_BIT = 18;
	localparam int COL2_W = 4;
	localparam int ROW3_W = 3;
	// ****************************************
	// fifth id byte fields
	// ****************************************
	localparam int ID5_PLANES_LSB = 2;
	localparam int ID5_PLANES_W = 2;
	localparam int ID5_SIZE_LSB = 4;
	localparam int ID5_SIZE_W = 3;
	// ****************************************
	// user operations
	// ****************************************
	typedef enum logic [2:0] {
		NFC_OP_CMD,
		NFC_OP_ADDR,
		NFC_OP_WRITE,
		NFC_OP_READ,
		NFC_OP_IDENT,
		NFC_OP_DIE_STATUS,
		NFC_OP_STATUS
	} nfc_op_type;
endpackage : nfc_pkg
`default_nettype wire

// ### rtl/nfc_buf2.sv
// nfc_buf2: two-entry valid/ready buffer on the read data path.
// assumes one clock domain; drain side may stall at any time.
`default_nettype none
module nfc_buf2 #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem [2];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;
	wire do_push = in_valid && in_ready;
	wire do_pop = out_valid && out_ready;
	assign in_ready = (count != 2'd2);
	assign out_valid = (count != 2'd0);
	assign out_data = mem[rd_ptr];
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'd0;
		end else begin
			if (do_push) begin
				mem[wr_ptr] <= in_data;
				wr_ptr <= ~wr_ptr;
			end
			if (do_pop) begin
				rd_ptr <= ~rd_ptr;
			end
			count <= count + {1'b0, do_push} - {1'b0, do_pop};
		end
	end
endmodule // nfc_buf2
`default_nettype wire

// ### rtl/nfc_addr_pack.sv
// nfc_addr_pack: splits column and row address into the five bus cycles.
// assumes row = block, plane and page concatenated, low bits first.
`default_nettype none
module nfc_addr_pack (
	input wire logic [nfc_pkg::COL_W-1:0] column_bit,
	input wire logic [nfc_pkg::ROW_W-1:0] row,
	input wire logic [2:0] index,
	output logic [7:0] addr_byte
);
	wire [7:0] cyc1 = column_bit[7:0];
	wire [7:0] cyc2 = {{(8 - nfc_pkg::COL2_W){1'b0}}, column_bit[nfc_pkg::COL_W-1:8]};
	wire [7:0] cyc3 = row[7:0];
	wire [7:0] cyc4 = row[15:8];
	wire [7:0] cyc5 = {{(8 - nfc_pkg::ROW3_W){1'b0}}, row[nfc_pkg::ROW_W-1:16]};
	assign addr_byte = (index == 3'd0) ? cyc1 :
		(index == 3'd1) ? cyc2 :
		(index == 3'd2) ? cyc3 :
		(index == 3'd3) ? cyc4 : cyc5;
endmodule // nfc_addr_pack
`default_nettype wire

// ### rtl/nfc_host.sv
// nfc_host: host controller driving a dual-die 8-bit nand device's command pins.
// assumes the device pins are sampled synchronously to clk; the busy line is
// sensed and the wp line driven from req_protect here, and the open-drain busy pull-up lies outside.
`default_nettype none
// Overview of operation
// - command byte latched with cmd strobe
// - address byte latched with addr strobe
// - column sent in cycles one, two
// - page bits on lines 0-5, cycle three
// - block bits in cycles three to five
// - die status command by row half
// - ident command then zero address
// - dummy command before status after ident
module nfc_host #(
	parameter int READ_MAX = 4096
) (
	input wire logic clk,
	input wire logic rst_n,
	// user side
	input wire logic req_valid,
	output logic req_ready,
	input wire nfc_pkg::nfc_op_type req_op,
	input wire logic [7:0] req_byte,
	input wire logic [nfc_pkg::COL_W-1:0] req_column,
	input wire logic [nfc_pkg::ROW_W-1:0] req_row,
	input wire logic [12:0] req_count,
	input wire logic req_protect,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [7:0] rd_data,
	output logic id5_valid,
	output logic [nfc_pkg::ID5_PLANES_W-1:0] id5_planes,
	output logic [nfc_pkg::ID5_SIZE_W-1:0] id5_plane_size,
	output logic device_ready,
	// device pins
	output logic chip_select_n,
	output logic cmd_latch,
	output logic addr_latch,
	output logic write_strobe_n,
	output logic read_strobe_n,
	output logic write_protect_n,
	input wire logic [7:0] shared_bus_in,
	output logic [7:0] shared_bus_out,
	output logic shared_bus_oe,
	input wire logic ready_busy_n
);
	// ****************************************
	// state
	// ****************************************
	typedef enum logic [2:0] {
		NFC_IDLE,
		NFC_WR_LOW,
		NFC_WR_HIGH,
		NFC_RD_LOW,
		NFC_RD_HIGH
	} nfc_state_type;
	typedef enum logic [1:0] {
		NFC_KIND_CMD,
		NFC_KIND_ADDR,
		NFC_KIND_DATA
	} nfc_kind_type;
	nfc_state_type state;
	nfc_kind_type kind;
	nfc_pkg::nfc_op_type op;
	logic [7:0] out_byte;
	logic [2:0] addr_idx;
	logic [2:0] addr_last;
	logic [12:0] remain;
	logic [nfc_pkg::CNT_W-1:0] cnt;
	logic [nfc_pkg::COL_W-1:0] col;
	logic [nfc_pkg::ROW_W-1:0] row;
	logic in_ident;
	logic need_dummy;
	logic [2:0] ident_pos;
	logic [7:0] pending_status_cmd;
	logic cap_valid;
	logic [7:0] cap_data;
	logic buf_in_ready;
	logic buf_out_valid;
	logic [7:0] buf_out_data;
	logic rdy_s;
	logic [7:0] addr_byte;
	// ****************************************
	// decode
	// ****************************************
	wire take = req_valid && req_ready;
	wire cnt_done = (cnt == '0);
	wire die_hi = req_row[nfc_pkg::ROW_DIE_BIT];
	wire [7:0] die_cmd = die_hi ? nfc_pkg::CMD_DIE1_STATUS : nfc_pkg::CMD_DIE0_STATUS;
	wire status_after_ident = (req_op == nfc_pkg::NFC_OP_STATUS) && need_dummy;
	wire [7:0] cmd_byte = (req_op == nfc_pkg::NFC_OP_IDENT) ? nfc_pkg::CMD_IDENT :
		(req_op == nfc_pkg::NFC_OP_DIE_STATUS) ? die_cmd :
		(req_op == nfc_pkg::NFC_OP_STATUS) ?
		(status_after_ident ? nfc_pkg::CMD_DUMMY : nfc_pkg::CMD_STATUS) : req_byte;
	wire is_cmd_op = (req_op == nfc_pkg::NFC_OP_CMD) || (req_op == nfc_pkg::NFC_OP_IDENT) ||
		(req_op == nfc_pkg::NFC_OP_DIE_STATUS) || (req_op == nfc_pkg::NFC_OP_STATUS);
	wire more_addr = (kind == NFC_KIND_ADDR) && (addr_idx != addr_last);
	wire chain_ident = (op == nfc_pkg::NFC_OP_IDENT) && (kind == NFC_KIND_CMD);
	wire chain_status = (kind == NFC_KIND_CMD) && (pending_status_cmd != nfc_pkg::CMD_DUMMY);
	wire read_after = (op == nfc_pkg::NFC_OP_DIE_STATUS) || (op == nfc_pkg::NFC_OP_STATUS);
	wire read_more = (remain != 13'd1);
	wire [7:0] next_addr_byte = (op == nfc_pkg::NFC_OP_IDENT) ? nfc_pkg::IDENT_ADDR : addr_byte;
	// the packer looks one byte ahead, so the next address byte is ready as the strobe drops
	nfc_addr_pack u_pack (
		.column_bit(col),
		.row(row),
		.index(addr_idx + 3'd1),
		.addr_byte(addr_byte)
	);
	// read path: a captured byte waits in the buffer until the user takes it
	nfc_buf2 #(
		.WIDTH(8)
	) u_buf (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(cap_valid),
		.in_ready(buf_in_ready),
		.in_data(cap_data),
		.out_valid(buf_out_valid),
		.out_ready(rd_ready),
		.out_data(buf_out_data)
	);
	// ****************************************
	// sequencer
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= NFC_IDLE;
			kind <= NFC_KIND_CMD;
			op <= nfc_pkg::NFC_OP_CMD;
			out_byte <= 8'h00;
			addr_idx <= 3'd0;
			addr_last <= 3'd0;
			remain <= 13'd0;
			cnt <= '0;
			col <= '0;
			row <= '0;
			in_ident <= 1'b0;
			need_dummy <= 1'b0;
			ident_pos <= 3'd0;
			pending_status_cmd <= nfc_pkg::CMD_DUMMY;
			cap_valid <= 1'b0;
			cap_data <= 8'h00;
			chip_select_n <= 1'b1;
			cmd_latch <= 1'b0;
			addr_latch <= 1'b0;
			write_strobe_n <= 1'b1;
			read_strobe_n <= 1'b1;
			shared_bus_out <= 8'h00;
			shared_bus_oe <= 1'b0;
			req_ready <= 1'b0;
			id5_valid <= 1'b0;
			id5_planes <= '0;
			id5_plane_size <= '0;
		end else begin
			cap_valid <= 1'b0;
			if (!cnt_done) begin
				cnt <= cnt - 1'b1;
			end
			case (state)
				NFC_IDLE: begin
					cmd_latch <= 1'b0;
					addr_latch <= 1'b0;
					shared_bus_oe <= 1'b0;
					req_ready <= rdy_s;
					if (take) begin
						req_ready <= 1'b0;
						chip_select_n <= 1'b0;
						op <= req_op;
						col <= req_column;
						row <= req_row;
						remain <= (req_count == 13'd0) ? 13'd1 : req_count;
						addr_idx <= 3'd0;
						addr_last <= (req_byte[2:0] == 3'd0) ? 3'(nfc_pkg::ADDR_CYCLES - 1) :
							3'(req_byte[2:0] - 3'd1);
						pending_status_cmd <= status_after_ident ? nfc_pkg::CMD_STATUS :
							nfc_pkg::CMD_DUMMY;
						if (req_op == nfc_pkg::NFC_OP_READ) begin
							state <= NFC_RD_LOW;
							cnt <= nfc_pkg::CNT_W'(nfc_pkg::STROBE_LOW_CYC - 1);
							read_strobe_n <= 1'b0;
						end else begin
							kind <= is_cmd_op ? NFC_KIND_CMD :
								(req_op == nfc_pkg::NFC_OP_ADDR) ? NFC_KIND_ADDR : NFC_KIND_DATA;
							cmd_latch <= is_cmd_op;
							addr_latch <= (req_op == nfc_pkg::NFC_OP_ADDR);
							out_byte <= cmd_byte;
							shared_bus_out <= cmd_byte;
							shared_bus_oe <= 1'b1;
							write_strobe_n <= 1'b0;
							state <= NFC_WR_LOW;
							cnt <= nfc_pkg::CNT_W'(nfc_pkg::STROBE_LOW_CYC - 1);
							if (is_cmd_op) begin
								// any command other than ident ends ident mode
								in_ident <= (req_op == nfc_pkg::NFC_OP_IDENT);
								ident_pos <= 3'd0;
								need_dummy <= (req_op == nfc_pkg::NFC_OP_IDENT) ||
									(status_after_ident ? 1'b0 :
									(need_dummy && (req_byte != nfc_pkg::CMD_DUMMY ||
									req_op != nfc_pkg::NFC_OP_CMD)));
							end
							// col is only loaded on this edge: the first byte comes straight
							// from the request
							if (req_op == nfc_pkg::NFC_OP_ADDR) begin
								shared_bus_out <= req_column[7:0];
								out_byte <= req_column[7:0];
							end
						end
					end else begin
						chip_select_n <= 1'b1;
					end
				end
				NFC_WR_LOW: begin
					if (cnt_done) begin
						// rising edge: the device latches the byte here
						write_strobe_n <= 1'b1;
						state <= NFC_WR_HIGH;
						cnt <= nfc_pkg::CNT_W'(nfc_pkg::STROBE_HIGH_CYC - 1);
					end
				end
				NFC_WR_HIGH: begin
					if (cnt_done) begin
						if (more_addr) begin
							addr_idx <= addr_idx + 3'd1;
							shared_bus_out <= addr_byte;
							state <= NFC_WR_LOW;
							write_strobe_n <= 1'b0;
							cnt <= nfc_pkg::CNT_W'(nfc_pkg::STROBE_LOW_CYC - 1);
						end else if (chain_status) begin
							shared_bus_out <= pending_status_cmd;
							pending_status_cmd <= nfc_pkg::CMD_DUMMY;
							state <= NFC_WR_LOW;
							write_strobe_n <= 1'b0;
							cnt <= nfc_pkg::CNT_W'(nfc_pkg::STROBE_LOW_CYC - 1);
						end else if (chain_ident) begin
							kind <= NFC_KIND_ADDR;
							cmd_latch <= 1'b0;
							addr_latch <= 1'b1;
							addr_last <= 3'd0;
							shared_bus_out <= next_addr_byte;
							state <= NFC_WR_LOW;
							write_strobe_n <= 1'b0;
							cnt <= nfc_pkg::CNT_W'(nfc_pkg::STROBE_LOW_CYC - 1);
						end else if (read_after) begin
							cmd_latch <= 1'b0;
							shared_bus_oe <= 1'b0;
							remain <= 13'd1;
							state <= NFC_RD_LOW;
							read_strobe_n <= 1'b0;
							cnt <= nfc_pkg::CNT_W'(nfc_pkg::STROBE_LOW_CYC - 1);
						end else begin
							state <= NFC_IDLE;
							cmd_latch <= 1'b0;
							addr_latch <= 1'b0;
							shared_bus_oe <= 1'b0;
						end
						if (kind == NFC_KIND_ADDR && !more_addr) begin
							shared_bus_out <= next_addr_byte;
						end
					end else if (kind == NFC_KIND_ADDR && cnt == nfc_pkg::CNT_W'(1)) begin
						shared_bus_out <= addr_byte;
					end
				end
				NFC_RD_LOW: begin
					// hold the strobe low while the buffer is full: no byte is lost
					if (cnt_done && buf_in_ready) begin
						read_strobe_n <= 1'b1;
						cap_valid <= 1'b1;
						cap_data <= shared_bus_in;
						state <= NFC_RD_HIGH;
						cnt <= nfc_pkg::CNT_W'(nfc_pkg::STROBE_HIGH_CYC - 1);
						if (in_ident) begin
							ident_pos <= ident_pos + 3'd1;
							if (ident_pos == 3'(nfc_pkg::IDENT_BYTES - 1)) begin
								id5_valid <= 1'b1;
								id5_planes <= shared_bus_in[nfc_pkg::ID5_PLANES_LSB +:
									nfc_pkg::ID5_PLANES_W];
								id5_plane_size <= shared_bus_in[nfc_pkg::ID5_SIZE_LSB +:
									nfc_pkg::ID5_SIZE_W];
							end
						end
					end
				end
				NFC_RD_HIGH: begin
					if (cnt_done) begin
						remain <= remain - 13'd1;
						if (read_more) begin
							state <= NFC_RD_LOW;
							read_strobe_n <= 1'b0;
							cnt <= nfc_pkg::CNT_W'(nfc_pkg::STROBE_LOW_CYC - 1);
						end else begin
							state <= NFC_IDLE;
						end
					end
				end
				default: begin
					state <= NFC_IDLE;
				end
			endcase
		end
	end
	// ****************************************
	// protect and busy sensing
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			write_protect_n <= 1'b0;
			rdy_s <= 1'b0;
			device_ready <= 1'b0;
		end else begin
			write_protect_n <= ~req_protect;
			rdy_s <= ready_busy_n;
			device_ready <= ready_busy_n;
		end
	end
	assign rd_valid = buf_out_valid;
	assign rd_data = buf_out_data;
	wire unused_ok = &{1'b0, READ_MAX[0], row[nfc_pkg::PLANE_POS], nfc_pkg::PAGE_W[0],
		out_byte[0]};
endmodule // nfc_host
`default_nettype wire

// ### dv/nfc_host_properties.sv
// nfc_host_properties: pin and handshake checks for the nand host controller.
// assumes it is bound to nfc_host and sees only its ports.
`default_nettype none
module nfc_host_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_ready,
	input wire logic rd_valid,
	input wire logic rd_ready,
	input wire logic [7:0] rd_data,
	input wire logic chip_select_n,
	input wire logic cmd_latch,
	input wire logic addr_latch,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic [7:0] shared_bus_out,
	input wire logic shared_bus_oe,
	input wire logic ready_busy_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ****************
	// latch tracking
	// ****************
	logic wq;
	logic idm;
	logic [2:0] acnt;
	// wr marks the first edge that sees a write strobe high again
	wire wr = write_strobe_n && !wq;
	always_ff @(posedge clk) begin
		wq <= write_strobe_n;
		if (!rst_n) begin
			acnt <= 3'h0;
			idm <= 1'b0;
		end else if (wr && cmd_latch) begin
			acnt <= 3'h0;
			idm <= shared_bus_out == 8'h90;
		end else if (wr && addr_latch) begin
			acnt <= acnt + 3'h1;
		end
	end
	sequence s_ident;
		wr && cmd_latch && shared_bus_out == 8'h90;
	endsequence
	sequence s_zero;
		wr && addr_latch && shared_bus_out == 8'h00;
	endsequence
	sequence s_die;
		wr && cmd_latch && shared_bus_out[7:1] == 7'h79;
	endsequence
	strobe_hold_a: assert property (!write_strobe_n |=> write_strobe_n &&
		$stable(shared_bus_out) && $stable(cmd_latch) && $stable(addr_latch))
		else $error("byte moved under write strobe");
	bus_drive_a: assert property (!write_strobe_n |->
		shared_bus_oe && !chip_select_n && read_strobe_n) else $error("write cycle undriven");
	no_fight_a: assert property (!read_strobe_n |->
		!shared_bus_oe && !chip_select_n) else $error("bus driven during read");
	col_high_a: assert property (wr && addr_latch && acnt == 3'h1 |->
		shared_bus_out[7:4] == 4'h0) else $error("column high nibble set");
	blk_high_a: assert property (wr && addr_latch && acnt == 3'h4 |->
		shared_bus_out[7:3] == 5'h00) else $error("last address cycle high bits set");
	ident_addr_a: assert property (s_ident |-> ##[1:3] s_zero)
		else $error("ident without zero address");
	dummy_first_a: assert property (wr && cmd_latch && shared_bus_out == 8'h70 |->
		!idm) else $error("status sent straight after ident");
	die_read_a: assert property (s_die |-> ##[1:60] !read_strobe_n)
		else $error("die status not read");
	// busy passes one sensing register before idle ready follows it
	busy_block_a: assert property (!ready_busy_n |=> ##1 !req_ready)
		else $error("request accepted while busy");
	rd_after_a: assert property ($rose(read_strobe_n) |=> rd_valid)
		else $error("read byte not delivered");
	rd_hold_a: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
		else $error("stalled read word lost");
endmodule // nfc_host_properties
`default_nettype wire

// ### dv/nfc_dev_model.sv
// nfc_dev_model: behavioural dual-die nand device behind the controller pins.
// assumes pins change just after clk rises; no array timing is modelled.
`default_nettype none
module nfc_dev_model #(
	parameter logic [39:0] IDS = 40'h5a_a5c3_3c24 // arbitrary id bytes, fifth last
) (
	input wire logic clk,
	input wire logic chip_select_n,
	input wire logic cmd_latch,
	input wire logic addr_latch,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic write_protect_n,
	input wire logic [7:0] shared_bus_in,
	input wire logic hold_busy,
	output logic [7:0] dev_bus,
	output logic ready_busy_n,
	output logic [39:0] abytes,
	output logic [7:0] wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wq = 1'b1, rq = 1'b1, idm = 1'b0, bad = 1'b0;
	logic [7:0] cmd = 8'h00, col = 8'h00, last = 8'h00, dout;
	logic [2:0] ai = 3'h0, idx = 3'h0;
	wire cap = !chip_select_n && write_strobe_n && !wq;
	always @(posedge clk) begin
		wq <= write_strobe_n;
		rq <= read_strobe_n;
		if (cap && cmd_latch) begin
			cmd <= shared_bus_in;
			idm <= shared_bus_in == 8'h90;
			bad <= idm && shared_bus_in == 8'h70;
			ai <= 3'h0;
			idx <= 3'h0;
		end
		if (cap && addr_latch) begin
			abytes[ai*8 +: 8] <= shared_bus_in;
			ai <= ai + 3'h1;
			idx <= 3'h0;
			if (ai == 3'h0) col <= shared_bus_in;
		end
		if (cap && !cmd_latch && !addr_latch) wdata <= shared_bus_in;
		if (read_strobe_n && !rq) idx <= idx + 3'h1;
		if (!read_strobe_n) last <= dout;
	end
	always_comb begin
		// a status asked without the dummy gets a wrong byte, as on silicon
		if (bad) dout = 8'hee;
		else if (idm) dout = IDS[(4 - idx) * 8 +: 8];
		else if (cmd == 8'h70) dout = {write_protect_n, 7'h60};
		else if (cmd[7:1] == 7'h79) dout = {write_protect_n, 6'h30, cmd[0]};
		else dout = col + {5'h00, idx};
	end
	// released bus shows the inverse of the last byte, never a stale copy
	assign dev_bus = (!chip_select_n && !read_strobe_n) ? dout : ~last;
	assign ready_busy_n = !hold_busy;
endmodule // nfc_dev_model
`default_nettype wire

// ### dv/test_nfc_host.sv
// test_nfc_host: self-checking bench for the nand host controller.
// assumes nfc_pkg, nfc_host, nfc_dev_model and the checker are compiled first.
`default_nettype none
module test_nfc_host;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [39:0] IDS = 40'h5a_a5c3_3c24; // arbitrary id bytes
	logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, rd_ready = 1'b0;
	logic req_protect = 1'b0, hold_busy = 1'b0, stall = 1'b0;
	nfc_pkg::nfc_op_type req_op = nfc_pkg::NFC_OP_CMD;
	logic [7:0] req_byte = 8'h00;
	logic [11:0] req_column = 12'h000;
	logic [18:0] req_row = 19'h0_0000;
	logic [12:0] req_count = 13'h0000;
	logic req_ready, rd_valid, id5_valid, device_ready, shared_bus_oe, ready_busy_n;
	logic chip_select_n, cmd_latch, addr_latch, write_strobe_n, read_strobe_n, write_protect_n;
	logic [7:0] rd_data, shared_bus_out, dev_bus, wdata;
	logic [1:0] id5_planes;
	logic [2:0] id5_plane_size;
	logic [39:0] abytes;
	wire [7:0] shared_bus_in = shared_bus_oe ? shared_bus_out : dev_bus;
	logic [31:0] seed = 32'h0000_0019;
	logic [7:0] expq[$];
	int fails = 0;
	int compares = 0;
	nfc_host dut (.*);
	nfc_dev_model #(.IDS(IDS)) model (.*);
	initial begin
		forever #25 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_rdy();
		for (int i = 0; i < 400 && req_ready !== 1'b1; i++) @(negedge clk);
		if (req_ready !== 1'b1) begin
			fails++;
			complete_run();
		end
	endtask
	task automatic req(input nfc_pkg::nfc_op_type op, input logic [7:0] b);
		wait_rdy();
		req_op = op;
		req_byte = b;
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		for (int i = 0; i < 4 && req_ready === 1'b1; i++) @(negedge clk);
	endtask
	task automatic drain();
		for (int i = 0; i < 400 && expq.size() != 0; i++) @(negedge clk);
		if (expq.size() != 0) begin
			fails++;
			complete_run();
		end
		wait_rdy();
	endtask
	// ****************
	// read side: random stalls, oldest note compared
	// ****************
	always @(negedge clk) begin
		logic nr;
		nr = !stall && (rnd() & 32'h3) != 32'h0;
		if (rd_valid === 1'b1 && nr) begin
			if (expq.size() == 0) chk(rd_data, 40'h100);
			else chk(rd_data, expq.pop_front());
		end
		rd_ready <= nr;
	end
	initial begin
		logic [31:0] v;
		repeat (20) @(negedge clk);
		chk({chip_select_n, write_strobe_n, read_strobe_n, shared_bus_oe, req_ready}, 40'h1c);
		rst_n = 1'b1;
		for (int k = 0; k < 3; k++) begin
			v = rnd();
			req_column = (k == 1) ? 12'hfff : v[11:0];
			req_row = (k == 1) ? 19'h7_ffff : v[30:12];
			req_count = 13'(k * 3 + 2);
			req(nfc_pkg::NFC_OP_CMD, 8'h00);
			req(nfc_pkg::NFC_OP_ADDR, 8'h00);
			wait_rdy();
			chk(abytes, {5'h00, req_row, 4'h0, req_column});
			for (int i = 0; i < k * 3 + 2; i++) expq.push_back(req_column[7:0] + 8'(i));
			stall = k == 2;
			req(nfc_pkg::NFC_OP_READ, 8'h00);
			repeat (20) @(negedge clk);
			stall = 1'b0;
			drain();
			$display("address and read pass %0d done", k);
		end
		req(nfc_pkg::NFC_OP_IDENT, 8'h00);
		for (int k = 4; k >= 0; k--) expq.push_back(IDS[k*8 +: 8]);
		req_count = 13'h0005;
		req(nfc_pkg::NFC_OP_READ, 8'h00);
		drain();
		chk({id5_valid, id5_planes, id5_plane_size}, {1'b1, IDS[3:2], IDS[6:4]});
		$display("ident test done");
		for (int k = 0; k < 2; k++) begin
			req_protect = !k[0];
			expq.push_back({k[0], 7'h60});
			req(nfc_pkg::NFC_OP_STATUS, 8'h00);
			drain();
			req_row = {k[0], 18'h0_0000};
			expq.push_back({k[0], 6'h30, k[0]});
			req(nfc_pkg::NFC_OP_DIE_STATUS, 8'h00);
			drain();
		end
		$display("status test done");
		v = rnd();
		req(nfc_pkg::NFC_OP_CMD, 8'h80);
		req(nfc_pkg::NFC_OP_WRITE, v[7:0]);
		wait_rdy();
		chk(wdata, v[7:0]);
		hold_busy = 1'b1;
		repeat (4) @(negedge clk);
		chk({req_ready, device_ready}, 40'h0);
		hold_busy = 1'b0;
		wait_rdy();
		chk(device_ready, 40'h1);
		$display("write and busy test done");
		complete_run();
	end
endmodule // test_nfc_host
bind nfc_host nfc_host_properties u_props (.*);
`default_nettype wire
